// >>> design/jtd_tap_top.sv
// Notes on behaviour
// - Instruction 8, bypass 1, ID 32, boundary 135 bits.
// - EXTEST captures ring, selects boundary register.
// - IDCODE loads ID value, selects ID register.
// - SAMPLE/PRELOAD captures ring, selects boundary register.
// - CLAMP selects bypass, outputs driven from cells.
// - HIGHZ selects bypass, all outputs high impedance.
// - BYPASS selects single-bit bypass register.
// - TMS high five edges resets test port.
// - Reset loads IDCODE into instruction register.
// - Capture-IR loads 01 into low bits.
// - TDI sampled rising, TDO updated falling.
`include "jtd_tap_map.svh"
`timescale 1ns/1ps
`default_nettype none

module jtd_tap_top #(
   parameter int IR_WIDTH = `JTD_IR_WIDTH,
   parameter int ID_WIDTH = `JTD_ID_WIDTH,
   parameter int BSR_WIDTH = `JTD_BSR_WIDTH,
   parameter logic [`JTD_ID_WIDTH-1:0] ID_VALUE = `JTD_ID_DEFAULT
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic testClk,
   input wire logic testModeSel,
   input wire logic testDataIn,
   output logic testDataOut,
   output logic testDataOutEn,
   input wire logic [BSR_WIDTH-1:0] ringIn,
   output logic [BSR_WIDTH-1:0] ringOut,
   output logic ringOutFromScan,
   output logic ringOutHighZ,
   output logic memHighZ
);

   // ****************************************************************
   // Parameter checks.
   // ****************************************************************
   initial begin
      if (IR_WIDTH != `JTD_IR_WIDTH) $error("jtd_tap_top: instruction width fixed by opcodes");
      if (ID_WIDTH != `JTD_ID_WIDTH) $error("jtd_tap_top: ID width must match ID value");
      if (BSR_WIDTH < 2) $error("jtd_tap_top: boundary register too short");
   end

   // ****************************************************************
   // Controller state, test clock domain.
   // ****************************************************************
   jtd_tap_pkg::jtd_state_t state_r, state_nxt;
   logic [2:0] tmsHigh_r, tmsHigh_nxt;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         jtd_tap_pkg::TEST_LOGIC_RESET: state_nxt = testModeSel ? jtd_tap_pkg::TEST_LOGIC_RESET : jtd_tap_pkg::RUN_IDLE;
         jtd_tap_pkg::RUN_IDLE: state_nxt = testModeSel ? jtd_tap_pkg::SELECT_DR : jtd_tap_pkg::RUN_IDLE;
         jtd_tap_pkg::SELECT_DR: state_nxt = testModeSel ? jtd_tap_pkg::SELECT_IR : jtd_tap_pkg::CAPTURE_DR;
         jtd_tap_pkg::CAPTURE_DR: state_nxt = testModeSel ? jtd_tap_pkg::EXIT1_DR : jtd_tap_pkg::SHIFT_DR;
         jtd_tap_pkg::SHIFT_DR: state_nxt = testModeSel ? jtd_tap_pkg::EXIT1_DR : jtd_tap_pkg::SHIFT_DR;
         jtd_tap_pkg::EXIT1_DR: state_nxt = testModeSel ? jtd_tap_pkg::UPDATE_DR : jtd_tap_pkg::PAUSE_DR;
         jtd_tap_pkg::PAUSE_DR: state_nxt = testModeSel ? jtd_tap_pkg::EXIT2_DR : jtd_tap_pkg::PAUSE_DR;
         jtd_tap_pkg::EXIT2_DR: state_nxt = testModeSel ? jtd_tap_pkg::UPDATE_DR : jtd_tap_pkg::SHIFT_DR;
         jtd_tap_pkg::UPDATE_DR: state_nxt = testModeSel ? jtd_tap_pkg::SELECT_DR : jtd_tap_pkg::RUN_IDLE;
         jtd_tap_pkg::SELECT_IR: state_nxt = testModeSel ? jtd_tap_pkg::TEST_LOGIC_RESET : jtd_tap_pkg::CAPTURE_IR;
         jtd_tap_pkg::CAPTURE_IR: state_nxt = testModeSel ? jtd_tap_pkg::EXIT1_IR : jtd_tap_pkg::SHIFT_IR;
         jtd_tap_pkg::SHIFT_IR: state_nxt = testModeSel ? jtd_tap_pkg::EXIT1_IR : jtd_tap_pkg::SHIFT_IR;
         jtd_tap_pkg::EXIT1_IR: state_nxt = testModeSel ? jtd_tap_pkg::UPDATE_IR : jtd_tap_pkg::PAUSE_IR;
         jtd_tap_pkg::PAUSE_IR: state_nxt = testModeSel ? jtd_tap_pkg::EXIT2_IR : jtd_tap_pkg::PAUSE_IR;
         jtd_tap_pkg::EXIT2_IR: state_nxt = testModeSel ? jtd_tap_pkg::UPDATE_IR : jtd_tap_pkg::SHIFT_IR;
         jtd_tap_pkg::UPDATE_IR: state_nxt = testModeSel ? jtd_tap_pkg::SELECT_DR : jtd_tap_pkg::RUN_IDLE;
         default: state_nxt = jtd_tap_pkg::TEST_LOGIC_RESET;
      endcase
      // Five consecutive high mode-select edges always force reset.
      tmsHigh_nxt = testModeSel ? ((tmsHigh_r == `JTD_RESET_TMS_EDGES) ? tmsHigh_r : tmsHigh_r + 3'h1) : 3'h0;
      if (testModeSel && tmsHigh_r >= `JTD_RESET_TMS_EDGES - 3'h1) begin
         state_nxt = jtd_tap_pkg::TEST_LOGIC_RESET;
      end
   end

   always_ff @(posedge testClk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= jtd_tap_pkg::TEST_LOGIC_RESET;
         tmsHigh_r <= 3'h0;
      end else begin
         state_r <= state_nxt;
         tmsHigh_r <= tmsHigh_nxt;
      end
   end

   // ****************************************************************
   // Ball states brought into the test clock domain.
   // ****************************************************************
   logic [BSR_WIDTH-1:0] ringInSync;

   jtd_sync2 #(
      .WIDTH(BSR_WIDTH)
   ) u_ring_sync (
      .clk(testClk),
      .rst_n(rst_n),
      .din(ringIn),
      .dout(ringInSync)
   );

   // ****************************************************************
   // Scan registers, sampled on the rising test clock.
   // ****************************************************************
   logic [IR_WIDTH-1:0] irShift_r, irShift_nxt, ir_r, ir_nxt;
   logic bypass_r, bypass_nxt;
   logic [ID_WIDTH-1:0] idShift_r, idShift_nxt;
   logic [BSR_WIDTH-1:0] bsrShift_r, bsrShift_nxt, bsrHold_r, bsrHold_nxt;
   jtd_tap_pkg::jtd_sel_t drSel;
   logic inTlr;

   always_comb begin
      case (ir_r)
         `JTD_OP_EXTEST, `JTD_OP_SAMPLE: drSel = jtd_tap_pkg::SEL_BSR;
         `JTD_OP_IDCODE: drSel = jtd_tap_pkg::SEL_ID;
         `JTD_OP_CLAMP, `JTD_OP_HIGHZ, `JTD_OP_BYPASS: drSel = jtd_tap_pkg::SEL_BYPASS;
         default: drSel = jtd_tap_pkg::SEL_BYPASS;
      endcase
   end

   always_comb begin
      inTlr = (state_r == jtd_tap_pkg::TEST_LOGIC_RESET);
      irShift_nxt = irShift_r;
      ir_nxt = ir_r;
      bypass_nxt = bypass_r;
      idShift_nxt = idShift_r;
      bsrShift_nxt = bsrShift_r;
      bsrHold_nxt = bsrHold_r;
      case (state_r)
         jtd_tap_pkg::CAPTURE_IR: irShift_nxt = {ir_r[IR_WIDTH-1:2], `JTD_IR_CAPTURE};
         jtd_tap_pkg::SHIFT_IR: irShift_nxt = {testDataIn, irShift_r[IR_WIDTH-1:1]};
         jtd_tap_pkg::UPDATE_IR: ir_nxt = irShift_r;
         jtd_tap_pkg::CAPTURE_DR: begin
            bypass_nxt = 1'b0;
            idShift_nxt = ID_VALUE;
            if (drSel == jtd_tap_pkg::SEL_BSR) begin
               bsrShift_nxt = ringInSync;
            end
         end
         jtd_tap_pkg::SHIFT_DR: begin
            case (drSel)
               jtd_tap_pkg::SEL_ID: idShift_nxt = {testDataIn, idShift_r[ID_WIDTH-1:1]};
               jtd_tap_pkg::SEL_BSR: bsrShift_nxt = {testDataIn, bsrShift_r[BSR_WIDTH-1:1]};
               default: bypass_nxt = testDataIn;
            endcase
         end
         jtd_tap_pkg::UPDATE_DR: begin
            if (drSel == jtd_tap_pkg::SEL_BSR) begin
               bsrHold_nxt = bsrShift_r;
            end
         end
         default: begin
         end
      endcase
      if (inTlr) begin
         ir_nxt = `JTD_OP_IDCODE;
      end
   end

   always_ff @(posedge testClk or negedge rst_n) begin
      if (!rst_n) begin
         irShift_r <= '0;
         ir_r <= `JTD_OP_IDCODE;
         bypass_r <= 1'b0;
         idShift_r <= '0;
         bsrShift_r <= '0;
         bsrHold_r <= '0;
      end else begin
         irShift_r <= irShift_nxt;
         ir_r <= ir_nxt;
         bypass_r <= bypass_nxt;
         idShift_r <= idShift_nxt;
         bsrShift_r <= bsrShift_nxt;
         bsrHold_r <= bsrHold_nxt;
      end
   end

   // ****************************************************************
   // Serial output, updated on the falling test clock.
   // ****************************************************************
   logic tdo_r, tdo_nxt, tdoEn_r, tdoEn_nxt;

   always_comb begin
      tdo_nxt = tdo_r;
      tdoEn_nxt = 1'b0;
      if (state_r == jtd_tap_pkg::SHIFT_IR) begin
         tdo_nxt = irShift_r[0];
         tdoEn_nxt = 1'b1;
      end else if (state_r == jtd_tap_pkg::SHIFT_DR) begin
         tdoEn_nxt = 1'b1;
         case (drSel)
            jtd_tap_pkg::SEL_ID: tdo_nxt = idShift_r[0];
            jtd_tap_pkg::SEL_BSR: tdo_nxt = bsrShift_r[0];
            default: tdo_nxt = bypass_r;
         endcase
      end
   end

   always_ff @(negedge testClk or negedge rst_n) begin
      if (!rst_n) begin
         tdo_r <= 1'b0;
         tdoEn_r <= 1'b0;
      end else begin
         tdo_r <= tdo_nxt;
         tdoEn_r <= tdoEn_nxt;
      end
   end

   assign testDataOut = tdo_r;
   assign testDataOutEn = tdoEn_r;

   // ****************************************************************
   // Ball control, test clock domain.
   // ****************************************************************
   logic fromScan_r, fromScan_nxt, highZ_r, highZ_nxt;

   always_comb begin
      fromScan_nxt = (ir_r == `JTD_OP_EXTEST) || (ir_r == `JTD_OP_CLAMP);
      highZ_nxt = (ir_r == `JTD_OP_HIGHZ);
   end

   always_ff @(posedge testClk or negedge rst_n) begin
      if (!rst_n) begin
         fromScan_r <= 1'b0;
         highZ_r <= 1'b0;
      end else begin
         fromScan_r <= fromScan_nxt;
         highZ_r <= highZ_nxt;
      end
   end

   assign ringOut = bsrHold_r;
   assign ringOutFromScan = fromScan_r;
   assign ringOutHighZ = highZ_r;

   // ****************************************************************
   // High-impedance level crossed into the memory clock domain.
   // ****************************************************************
   jtd_sync2 #(
      .WIDTH(1)
   ) u_highz_sync (
      .clk(mclk),
      .rst_n(rst_n),
      .din(highZ_r),
      .dout(memHighZ)
   );

endmodule

`default_nettype wire

// >>> design/jtd_tap_map.svh
`ifndef JTD_TAP_MAP_SVH
`define JTD_TAP_MAP_SVH

// ****************************************************************
// Scan register sizes.
// ****************************************************************
`define JTD_IR_WIDTH 8
`define JTD_ID_WIDTH 32
`define JTD_BSR_WIDTH 135

// ****************************************************************
// Instruction codes.
// ****************************************************************
`define JTD_OP_EXTEST 8'h00
`define JTD_OP_IDCODE 8'h21
`define JTD_OP_SAMPLE 8'h05
`define JTD_OP_CLAMP 8'h07
`define JTD_OP_HIGHZ 8'h03
`define JTD_OP_BYPASS 8'hFF

// ****************************************************************
// Capture pattern, reset count and identification value.
// ****************************************************************
`define JTD_IR_CAPTURE 2'h1
`define JTD_RESET_TMS_EDGES 3'h5
`define JTD_ID_DEFAULT 32'h0000_0001

`endif

// >>> design/jtd_tap_pkg.sv
package jtd_tap_pkg;

   typedef enum logic [15:0] {
      TEST_LOGIC_RESET = 16'h0001,
      RUN_IDLE = 16'h0002,
      SELECT_DR = 16'h0004,
      CAPTURE_DR = 16'h0008,
      SHIFT_DR = 16'h0010,
      EXIT1_DR = 16'h0020,
      PAUSE_DR = 16'h0040,
      EXIT2_DR = 16'h0080,
      UPDATE_DR = 16'h0100,
      SELECT_IR = 16'h0200,
      CAPTURE_IR = 16'h0400,
      SHIFT_IR = 16'h0800,
      EXIT1_IR = 16'h1000,
      PAUSE_IR = 16'h2000,
      EXIT2_IR = 16'h4000,
      UPDATE_IR = 16'h8000
   } jtd_state_t;

   typedef enum logic [1:0] {
      SEL_BYPASS = 2'h0,
      SEL_ID = 2'h1,
      SEL_BSR = 2'h2
   } jtd_sel_t;

endpackage

// >>> design/jtd_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module jtd_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage_r;
   logic [WIDTH-1:0] out_r;

   initial begin
      if (WIDTH < 1) $error("jtd_sync2: WIDTH must be positive");
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage_r <= '0;
         out_r <= '0;
      end else begin
         stage_r <= din;
         out_r <= stage_r;
      end
   end

   assign dout = out_r;

endmodule

`default_nettype wire

// >>> verif/jtd_tap_props_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker.
// ****************************************************************
module jtd_tap_props #(
   parameter int BSR_WIDTH = 135
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic testClk,
   input wire logic testModeSel,
   input wire logic testDataOutEn,
   input wire logic [BSR_WIDTH-1:0] ringOut,
   input wire logic ringOutFromScan,
   input wire logic ringOutHighZ,
   input wire logic memHighZ
);
   property p_excl; @(posedge testClk) disable iff (!rst_n) !(ringOutFromScan && ringOutHighZ); endproperty
   a_excl: assert property (p_excl) else $error("clamp and high-z both set");
   property p_mem; @(posedge mclk) disable iff (!rst_n) memHighZ == $past(ringOutHighZ, 2); endproperty
   a_mem: assert property (p_mem) else $error("core high-z lags wrongly");
   property p_rstctl; @(posedge testClk) disable iff (!rst_n) testModeSel [*5] |-> ##3 !ringOutFromScan && !ringOutHighZ; endproperty
   a_rstctl: assert property (p_rstctl) else $error("controls kept after mode reset");
   property p_rsten; @(posedge testClk) disable iff (!rst_n) testModeSel [*5] |=> !testDataOutEn; endproperty
   a_rsten: assert property (p_rsten) else $error("serial out enabled after mode reset");
   property p_enrise; @(posedge testClk) disable iff (!rst_n) $rose(testDataOutEn) |-> !$past(testModeSel); endproperty
   a_enrise: assert property (p_enrise) else $error("serial out enabled off shift entry");
   property p_enfall; @(posedge testClk) disable iff (!rst_n) $fell(testDataOutEn) |-> $past(testModeSel); endproperty
   a_enfall: assert property (p_enfall) else $error("serial out dropped off shift exit");
   property p_ring; @(posedge testClk) disable iff (!rst_n) !$stable(ringOut) |-> $past(testModeSel, 2) && !ringOutHighZ; endproperty
   a_ring: assert property (p_ring) else $error("ring out changed off update");
   property p_ctl; @(posedge testClk) disable iff (!rst_n) $rose(ringOutFromScan) || $rose(ringOutHighZ) |-> $past(testModeSel, 3); endproperty
   a_ctl: assert property (p_ctl) else $error("control rose off instruction update");
endmodule
bind jtd_tap_top jtd_tap_props #(.BSR_WIDTH(BSR_WIDTH)) jtd_tap_props_i (.mclk, .rst_n, .testClk, .testModeSel,
   .testDataOutEn, .ringOut, .ringOutFromScan, .ringOutHighZ, .memHighZ);
`default_nettype wire

// >>> verif/jtd_tap_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Test controller model.
// ****************************************************************
module jtd_tap_ctrl (
   output logic testClk,
   output logic testModeSel,
   output logic testDataIn,
   input wire logic testDataOut
);
   logic tdoS;
   initial begin
      testClk = 1'b0;
      testModeSel = 1'b1;
      testDataIn = 1'b0;
   end
   task automatic tick(input logic m, input logic d);
      testModeSel = m;
      testDataIn = d;
      #3 tdoS = testDataOut;
      testClk = 1'b1;
      #3 testClk = 1'b0;
   endtask
   task automatic reset5();
      repeat (5) tick(1'b1, 1'b0);
      tick(1'b0, 1'b0);
   endtask
   task automatic scan(input logic ir, input int n, input logic [135:0] din, output logic [135:0] dout);
      dout = '0;
      tick(1'b1, 1'b0);
      if (ir) tick(1'b1, 1'b0);
      tick(1'b0, 1'b0);
      tick(1'b0, 1'b0);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i]);
         dout[i] = tdoS;
      end
      tick(1'b1, 1'b0);
      tick(1'b0, 1'b0);
   endtask
endmodule
`default_nettype wire

// >>> verif/jtd_tap_instruction_decode_test.sv
`include "jtd_tap_map.svh"
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Testbench.
// ****************************************************************
module jtd_tap_instruction_decode_test;
   localparam logic [31:0] IdVal = 32'h5A3C_0F81; // Arbitrary value.
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic testClk, testModeSel, testDataIn, testDataOut, testDataOutEn, ringOutFromScan, ringOutHighZ, memHighZ;
   logic [134:0] ringIn = '0;
   logic [134:0] ringOut, expRing;
   logic [135:0] pat = {4'h9, {33{4'hC}}};
   int err_count = 0;
   int total_checks = 0;
   always #50 mclk = ~mclk;
   jtd_tap_top #(.ID_VALUE(IdVal)) jtd_tap_top_i (.mclk, .rst_n, .testClk, .testModeSel, .testDataIn,
      .testDataOut, .testDataOutEn, .ringIn, .ringOut, .ringOutFromScan, .ringOutHighZ, .memHighZ);
   jtd_tap_ctrl jtd_tap_ctrl_i (.testClk, .testModeSel, .testDataIn, .testDataOut);
   task automatic chk(input string nm, input logic [135:0] exp, input logic [135:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic dr_check(input string nm, input int len, input logic [135:0] cap);
      logic [135:0] o;
      jtd_tap_ctrl_i.scan(1'b0, 136, pat, o);
      chk(nm, (pat << len) | cap, o);
   endtask
   task automatic t_codes();
      logic [7:0] ops [7] = '{`JTD_OP_EXTEST, `JTD_OP_IDCODE, `JTD_OP_SAMPLE, `JTD_OP_CLAMP, `JTD_OP_HIGHZ,
         `JTD_OP_BYPASS, 8'h5A};
      logic [135:0] c;
      logic [7:0] prev;
      logic bsr;
      prev = `JTD_OP_IDCODE;
      expRing = '0;
      for (int i = 0; i < 7; i++) begin
         @(posedge mclk) ringIn <= {27{5'h13 ^ i[4:0]}};
         pat = {pat[3:0], pat[135:4]};
         jtd_tap_ctrl_i.scan(1'b1, 8, {128'h0, ops[i]}, c);
         jtd_tap_ctrl_i.tick(1'b0, 1'b0);
         chk("irCapture", {128'h0, prev[7:2], 2'b01}, c);
         prev = ops[i];
         repeat (4) @(posedge mclk);
         chk("controls", 136'({ops[i] == `JTD_OP_EXTEST || ops[i] == `JTD_OP_CLAMP, ops[i] == `JTD_OP_HIGHZ,
            ops[i] == `JTD_OP_HIGHZ}), 136'({ringOutFromScan, ringOutHighZ, memHighZ}));
         bsr = ops[i] == `JTD_OP_EXTEST || ops[i] == `JTD_OP_SAMPLE;
         dr_check("dataPath", bsr ? 135 : (ops[i] == `JTD_OP_IDCODE ? 32 : 1),
            bsr ? 136'(ringIn) : (ops[i] == `JTD_OP_IDCODE ? 136'(IdVal) : 136'h0));
         if (bsr) expRing = pat[135:1];
         chk("ringOut", 136'(expRing), 136'(ringOut));
      end
   endtask
   task automatic t_tms_reset();
      logic [135:0] c;
      jtd_tap_ctrl_i.scan(1'b1, 8, {128'h0, `JTD_OP_HIGHZ}, c);
      chk("irCaptureLast", 136'(8'h59), c);
      jtd_tap_ctrl_i.reset5();
      chk("highZAfterReset", 136'h0, 136'(ringOutHighZ));
      dr_check("idAfterReset", 32, 136'(IdVal));
   endtask
   initial begin
      @(posedge mclk);
      jtd_tap_ctrl_i.tick(1'b1, 1'b0);
      @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      jtd_tap_ctrl_i.reset5();
      dr_check("idAtStart", 32, 136'(IdVal));
      t_codes();
      t_tms_reset();
      give_verdict();
   end
   initial begin
      #5000000;
      err_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
